/* inc/pmc_pkg.sv */
// Shared constants for the pressure measurement control block.
package pmc_pkg;

   // -----------------------------------------------------------------
   // Register map (byte addresses on the AHB-Lite slave)
   // -----------------------------------------------------------------
   localparam int ADDR_W = 6; // Decoded address bits.
   localparam logic [5:0] A_ID = 6'h00; // Identification register.
   localparam logic [5:0] A_CMD = 6'h04; // Command register.
   localparam logic [5:0] A_MODE = 6'h08; // Power mode and output rate.
   localparam logic [5:0] A_OSR = 6'h0c; // Oversampling and enable.
   localparam logic [5:0] A_FSEL = 6'h10; // FIFO frame selection.
   localparam logic [5:0] A_IIR = 6'h14; // Filter coefficients.
   localparam logic [5:0] A_DSP = 6'h18; // Flush and source selects.
   localparam logic [5:0] A_NVM = 6'h1c; // NVM operation register.
   localparam logic [5:0] A_STAT = 6'h20; // Status.
   localparam logic [5:0] A_TEMP = 6'h24; // Temperature data.
   localparam logic [5:0] A_PRESS = 6'h28; // Pressure data.

   // -----------------------------------------------------------------
   // Field layout and codes
   // -----------------------------------------------------------------
   localparam int F_ODR = 2; // Output rate field, five bits.
   localparam int F_DDIS = 7; // Deep standby disable bit.
   localparam int F_OSRP = 3; // Pressure oversampling field.
   localparam int F_PEN = 6; // Pressure enable bit.
   localparam int F_IIRP = 3; // Pressure filter field.
   localparam int F_SEL = 1; // First of five source select bits.
   localparam logic [7:0] ID_VALUE = 8'h5a; // Arbitrary identity value.
   localparam logic [7:0] CMD_SRST = 8'hb6; // Soft reset command.
   localparam logic [1:0] M_STBY = 2'b00; // Standby.
   localparam logic [1:0] M_NORM = 2'b01; // Normal.
   localparam logic [1:0] M_FORC = 2'b10; // Forced.
   localparam logic [1:0] M_CONT = 2'b11; // Continuous.
   localparam logic [4:0] ODR_DEEP_MIN = 5'h10; // Slow codes allow deep.
   localparam int DW = 24; // Sample width.

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25; // 40 MHz clock.
   localparam int T_STANDBY_NS = 2000; // Longest standby transition.
   localparam int T_POWERUP_NS = 20000; // Least power-up time.
   localparam int T_SOFTRES_NS = 10000; // Least soft reset time.
   localparam int T_RECONF_NS = 5000; // Least reconfiguration time.
   localparam int T_RECONF_DEEP_NS = 10000; // Same from deep standby.
   localparam int T_CONV_UNIT_NS = 1000; // Conversion time per factor.
   localparam int T_ODR_UNIT_NS = 200000; // Output period per rate code.
   localparam logic [23:0] STANDBY_CYC = 24'(T_STANDBY_NS / CLK_PERIOD_NS);
   localparam logic [23:0] POWERUP_CYC =
      24'((T_POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [23:0] SOFTRES_CYC =
      24'((T_SOFTRES_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [23:0] RECONF_CYC =
      24'((T_RECONF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [23:0] RECONF_DEEP_CYC =
      24'((T_RECONF_DEEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [23:0] CONV_UNIT_CYC =
      24'((T_CONV_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Sequencer states.
   typedef enum logic [2:0] {
      S_BOOT, S_STBY, S_GOSTBY, S_WAIT, S_CONV_T, S_CONV_P, S_IDLE
   } pmc_state_t;

endpackage

/* rtl/pmc_sync.sv */
// Two-flop synchroniser for the raw sample inputs.
`timescale 1ns/1ps
module pmc_sync #(
   parameter int W = 48 // Width of the synchronised bus.
) (
   input wire logic hclk, // System clock.
   input wire logic hresetn, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable.
   input wire logic [W-1:0] d, // Asynchronous input.
   output logic [W-1:0] q // Synchronised output.
);

   logic [W-1:0] meta_r; // First stage, read only by the second.

   // Both stages advance together while enabled.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_r <= '0;
         q <= '0;
      end else if (ce) begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule // pmc_sync

/* rtl/pmc_iir.sv */
// One channel of the low-pass filter with a power-of-two denominator.
`timescale 1ns/1ps
module pmc_iir
   import pmc_pkg::*;
(
   input wire logic hclk, // System clock.
   input wire logic hresetn, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable.
   input wire logic clr, // Empties the filter state.
   input wire logic load, // A new raw sample is present.
   input wire logic [2:0] code, // Coefficient code, zero bypasses.
   input wire logic [pmc_pkg::DW-1:0] din, // Raw sample.
   output logic [pmc_pkg::DW-1:0] dout // Filtered value.
);

   logic primed_r; // State holds a valid previous value.
   logic [DW+7:0] acc; // Previous times coefficient plus new sample.

   // Coefficient is 2^code - 1, so the product is a shift minus the
   // value and the divide by coefficient plus one is a right shift.
   always_comb begin
      acc = ({8'h00, dout} << code) - {8'h00, dout} + {8'h00, din};
   end

   // Bypass or first sample after a clear load the raw value directly.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dout <= '0;
         primed_r <= 1'b0;
      end else if (ce) begin
         // A clear that meets a sample restarts from that sample.
         if (load) begin
            primed_r <= 1'b1;
            if (code == 3'h0 || !primed_r || clr) begin
               dout <= din;
            end else begin
               dout <= DW'(acc >> code);
            end
         end else if (clr) begin
            primed_r <= 1'b0;
         end
      end
   end

endmodule // pmc_iir

/* rtl/pmc_top.sv */
// Power mode sequencer, measurement control and register file.
//
// The address map and the AHB-Lite slave port were decided locally.
`timescale 1ns/1ps
// Summary of operation
// - Continuous mode ignores rate, no idle phase.
// - Mode code zero reaches standby within limit.
// - Mode field reads back the actual mode.
// - From standby, mode write starts chosen mode.
// - First measurement starts on mode entry.
// - Standby-only writes dropped outside standby.
// - NVM, FIFO and filter settings are standby-only.
// - Command 0xb6 resets, ready after delay.
// - Pressure measured if enabled or frame selects.
// - Conversion time scales with oversampling.
// - Three-bit oversampling codes, factor doubles.
// - Oversampling change, or rate change in normal mode, restarts after reconfiguration time, except in forced mode.
// - Filter: previous times coefficient plus sample.
// - Three-bit filter codes, zero bypasses.
// - Filter cleared entering normal or continuous.
// - Flush bit clears filter on demand.
// - Five bits select filtered or raw sources.
// - Reset and soft reset settle in deep standby.
// - Active modes change only through standby.
// - Forced mode measures once, returns to standby.
// - Normal mode alternates measure and idle phases.
module pmc_top
   import pmc_pkg::*;
#(
   parameter int unsigned ODR_UNIT_CYC =
      pmc_pkg::T_ODR_UNIT_NS / pmc_pkg::CLK_PERIOD_NS // Rate step.
) (
   input wire logic hclk, // System clock, 40 MHz.
   input wire logic hresetn, // Asynchronous reset, active low.
   input wire logic ce, // Clock enable, freezes state when low.
   input wire logic hsel, // Slave select.
   input wire logic [31:0] haddr, // Byte address.
   input wire logic [1:0] htrans, // Transfer type.
   input wire logic hwrite, // Write strobe.
   input wire logic [2:0] hsize, // Transfer size.
   input wire logic [31:0] hwdata, // Write data.
   input wire logic hready, // Bus ready.
   output logic [31:0] hrdata, // Read data.
   output logic hreadyout, // Slave ready.
   output logic hresp, // Response, always OKAY.
   input wire logic [pmc_pkg::DW-1:0] raw_temp, // Raw temperature pins.
   input wire logic [pmc_pkg::DW-1:0] raw_press, // Raw pressure pins.
   output logic conv_busy, // A conversion is running.
   output logic conv_press, // The running conversion is pressure.
   output logic fifo_wr, // One-cycle strobe for new FIFO data.
   output logic [pmc_pkg::DW-1:0] fifo_t_data, // Temperature to FIFO.
   output logic [pmc_pkg::DW-1:0] fifo_p_data, // Pressure to FIFO.
   output logic [pmc_pkg::DW-1:0] oor_p_data // Pressure to range check.
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   pmc_state_t state_r; // Sequencer state.
   logic [23:0] cnt_r; // Phase counter.
   logic [23:0] per_r; // Output period counter for normal mode.
   logic [1:0] cur_mode_r; // Mode actually in force.
   logic [7:0] mode_r; // Rate and deep disable; mode bits unused.
   logic [6:0] osr_r; // Oversampling codes and pressure enable.
   logic [1:0] fsel_r; // FIFO frame selection.
   logic [5:0] iir_r; // Filter codes.
   logic [5:0] dsp_r; // Source selects; bit 0 reads as zero.
   logic [7:0] nvm_r; // NVM operation register.
   logic srst_r; // Soft reset pulse.
   logic flush_r; // Filter flush pulse.
   logic fclr_r; // Filter clear on mode entry.
   logic done_r; // Measurement finished this cycle.
   logic done_d_r; // Filter outputs are valid.
   logic dph_wr_r; // Data phase of a write is pending.
   logic [ADDR_W-1:0] dph_addr_r; // Address of the pending write.
   logic [DW-1:0] temp_r; // Temperature data register.
   logic [DW-1:0] press_r; // Pressure data register.
   logic [2*DW-1:0] raw_s; // Synchronised raw samples.
   logic [DW-1:0] filt [2]; // Filter outputs, 0 temperature.
   logic [2:0] fcode [2]; // Filter codes per channel.
   logic [DW-1:0] rsamp [2]; // Raw samples per channel.
   logic fload [2]; // Load strobes per channel.
   logic wr_en; // A register write completes now.
   logic mode_wr; // Write to the mode register.
   logic restart; // A change forces a reconfiguration restart.
   logic pt_en; // Pressure will be measured.
   logic deep_ok; // Deep standby conditions hold.
   logic [23:0] conv_t_cyc; // Temperature conversion length.
   logic [23:0] conv_p_cyc; // Pressure conversion length.
   logic [23:0] odr_cyc; // Normal mode output period.
   logic [31:0] rd_mux; // Read data for the address phase.

   // ----------------------------------------------------------------
   // Derived controls
   // ----------------------------------------------------------------

   // Decodes writes and the settings that steer the sequencer.
   always_comb begin
      wr_en = dph_wr_r && (state_r != S_BOOT);
      mode_wr = wr_en && (dph_addr_r == A_MODE);
      pt_en = osr_r[F_PEN] || fsel_r[1];
      deep_ok = !mode_r[F_DDIS] && (mode_r[F_ODR+:5] >= ODR_DEEP_MIN)
         && (fsel_r == 2'b00) && (iir_r == 6'h00);
      conv_t_cyc = CONV_UNIT_CYC << osr_r[2:0];
      conv_p_cyc = CONV_UNIT_CYC << osr_r[F_OSRP+:3];
      odr_cyc = 24'(ODR_UNIT_CYC * (32'(mode_r[F_ODR+:5]) + 32'd1));
      restart = (wr_en && dph_addr_r == A_OSR && hwdata[6:0] != osr_r)
         || (mode_wr && cur_mode_r == M_NORM
         && hwdata[F_ODR+:5] != mode_r[F_ODR+:5]);
   end

   // ----------------------------------------------------------------
   // AHB-Lite slave
   // ----------------------------------------------------------------

   // Read multiplexer; unmapped addresses and boot time read zero.
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (state_r != S_BOOT) begin
         case (haddr[ADDR_W-1:0])
            A_ID: rd_mux = {24'h00_0000, ID_VALUE};
            A_MODE: rd_mux = {24'h00_0000, mode_r[7:2], cur_mode_r};
            A_OSR: rd_mux = {25'h000_0000, osr_r};
            A_FSEL: rd_mux = {30'h0000_0000, fsel_r};
            A_IIR: rd_mux = {26'h000_0000, iir_r};
            A_DSP: rd_mux = {26'h000_0000, dsp_r};
            A_NVM: rd_mux = {24'h00_0000, nvm_r};
            A_STAT: rd_mux = {28'h000_0000, conv_busy, pt_en,
               state_r == S_STBY && deep_ok, 1'b1};
            A_TEMP: rd_mux = {8'h00, temp_r};
            A_PRESS: rd_mux = {8'h00, press_r};
            default: rd_mux = 32'h0000_0000;
         endcase
      end
   end

   // Takes each address phase; the slave never inserts wait states.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dph_wr_r <= 1'b0;
         dph_addr_r <= '0;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else if (ce) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         dph_wr_r <= hsel && htrans[1] && hready && hwrite;
         dph_addr_r <= haddr[ADDR_W-1:0];
         if (hsel && htrans[1] && hready && !hwrite) begin
            hrdata <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------

   // Registers writable in any mode; a soft reset restores them.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_r <= {1'b0, ODR_DEEP_MIN, M_STBY};
         osr_r <= 7'h00;
         dsp_r <= 6'h00;
         srst_r <= 1'b0;
         flush_r <= 1'b0;
      end else if (ce) begin
         srst_r <= wr_en && dph_addr_r == A_CMD
            && hwdata[7:0] == CMD_SRST;
         flush_r <= wr_en && dph_addr_r == A_DSP && hwdata[0];
         if (srst_r) begin
            mode_r <= {1'b0, ODR_DEEP_MIN, M_STBY};
            osr_r <= 7'h00;
            dsp_r <= 6'h00;
         end else if (wr_en) begin
            case (dph_addr_r)
               A_MODE: mode_r <= {hwdata[7:2], 2'b00};
               A_OSR: osr_r <= hwdata[6:0];
               A_DSP: dsp_r <= {hwdata[5:1], 1'b0};
               default: ;
            endcase
         end
      end
   end

   // Standby-only registers drop writes in any other mode.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fsel_r <= 2'b00;
         iir_r <= 6'h00;
         nvm_r <= 8'h00;
      end else if (ce) begin
         if (srst_r) begin
            fsel_r <= 2'b00;
            iir_r <= 6'h00;
            nvm_r <= 8'h00;
         end else if (wr_en && state_r == S_STBY) begin
            case (dph_addr_r)
               A_FSEL: fsel_r <= hwdata[1:0];
               A_IIR: iir_r <= hwdata[5:0];
               A_NVM: nvm_r <= hwdata[7:0];
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Mode sequencer
   // ----------------------------------------------------------------

   // Walks the power modes and the conversion phases.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_r <= S_BOOT;
         cnt_r <= POWERUP_CYC;
         cur_mode_r <= M_STBY;
         fclr_r <= 1'b0;
         done_r <= 1'b0;
      end else if (ce) begin
         fclr_r <= 1'b0;
         done_r <= 1'b0;
         if (srst_r) begin
            state_r <= S_BOOT;
            cnt_r <= SOFTRES_CYC;
            cur_mode_r <= M_STBY;
            fclr_r <= 1'b1;
         end else begin
            case (state_r)
               S_BOOT: begin
                  if (cnt_r == 24'h00_0000) begin
                     state_r <= S_STBY;
                  end else begin
                     cnt_r <= cnt_r - 24'h00_0001;
                  end
               end
               S_STBY: begin
                  if (mode_wr && hwdata[1:0] != M_STBY) begin
                     cur_mode_r <= hwdata[1:0];
                     state_r <= S_CONV_T;
                     cnt_r <= conv_t_cyc;
                     fclr_r <= hwdata[1:0] != M_FORC;
                  end
               end
               S_GOSTBY: begin
                  if (cnt_r == 24'h00_0000) begin
                     state_r <= S_STBY;
                     cur_mode_r <= M_STBY;
                  end else begin
                     cnt_r <= cnt_r - 24'h00_0001;
                  end
               end
               default: begin
                  if (mode_wr && hwdata[1:0] == M_STBY) begin
                     state_r <= S_GOSTBY;
                     cnt_r <= STANDBY_CYC;
                  end else if (restart && cur_mode_r != M_FORC) begin
                     state_r <= S_WAIT;
                     cnt_r <= (cur_mode_r == M_NORM && deep_ok) ?
                        RECONF_DEEP_CYC : RECONF_CYC;
                  end else if (state_r == S_IDLE) begin
                     if (per_r == 24'h00_0000) begin
                        state_r <= S_CONV_T;
                        cnt_r <= conv_t_cyc;
                     end
                  end else if (cnt_r != 24'h00_0000) begin
                     cnt_r <= cnt_r - 24'h00_0001;
                  end else if (state_r == S_WAIT) begin
                     state_r <= S_CONV_T;
                     cnt_r <= conv_t_cyc;
                  end else if (state_r == S_CONV_T && pt_en) begin
                     state_r <= S_CONV_P;
                     cnt_r <= conv_p_cyc;
                  end else begin
                     done_r <= 1'b1;
                     case (cur_mode_r)
                        M_FORC: begin
                           state_r <= S_STBY;
                           cur_mode_r <= M_STBY;
                        end
                        M_CONT: begin
                           state_r <= S_CONV_T;
                           cnt_r <= conv_t_cyc;
                        end
                        default: state_r <= S_IDLE;
                     endcase
                  end
               end
            endcase
         end
      end
   end

   // Output period timer, restarted at each temperature phase start.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         per_r <= 24'h00_0000;
      end else if (ce) begin
         if (state_r != S_CONV_T && state_r != S_CONV_P
            && state_r != S_IDLE) begin
            per_r <= odr_cyc - 24'h00_0003;
         end else if (state_r == S_IDLE && per_r == 24'h00_0000) begin
            per_r <= odr_cyc - 24'h00_0002;
         end else if (per_r != 24'h00_0000) begin
            per_r <= per_r - 24'h00_0001;
         end
      end
   end

   // ----------------------------------------------------------------
   // Sample path
   // ----------------------------------------------------------------

   pmc_sync #(.W(2 * DW)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .ce(ce),
      .d({raw_press, raw_temp}),
      .q(raw_s)
   );

   // One filter per channel, channel 0 temperature and 1 pressure.
   for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      assign fcode[ch] = iir_r[ch*F_IIRP+:3];
      assign rsamp[ch] = raw_s[ch*DW+:DW];
      assign fload[ch] = done_r && (ch == 0 || pt_en);
      pmc_iir u_iir (
         .hclk(hclk),
         .hresetn(hresetn),
         .ce(ce),
         .clr(fclr_r || flush_r),
         .load(fload[ch]),
         .code(fcode[ch]),
         .din(rsamp[ch]),
         .dout(filt[ch])
      );
   end

   // Routes filtered or raw values to each consumer.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         done_d_r <= 1'b0;
         fifo_wr <= 1'b0;
         temp_r <= '0;
         press_r <= '0;
         fifo_t_data <= '0;
         fifo_p_data <= '0;
         oor_p_data <= '0;
         conv_busy <= 1'b0;
         conv_press <= 1'b0;
      end else if (ce) begin
         conv_busy <= state_r == S_CONV_T || state_r == S_CONV_P;
         conv_press <= state_r == S_CONV_P;
         done_d_r <= done_r;
         fifo_wr <= done_d_r && fsel_r != 2'b00;
         if (done_d_r) begin
            temp_r <= dsp_r[F_SEL] ? filt[0] : rsamp[0];
            fifo_t_data <= dsp_r[F_SEL+1] ? filt[0] : rsamp[0];
            if (pt_en) begin
               press_r <= dsp_r[F_SEL+2] ? filt[1] : rsamp[1];
               fifo_p_data <= dsp_r[F_SEL+3] ? filt[1] : rsamp[1];
               oor_p_data <= dsp_r[F_SEL+4] ? filt[1] : rsamp[1];
            end
         end
      end
   end

endmodule // pmc_top

/* verification/pmc_chk.sv */
// Port checks for the measurement control block.
`timescale 1ns/1ps
module pmc_chk (
   input wire logic hclk, // Clock.
   input wire logic hresetn, // Reset, active low.
   input wire logic hsel, // Select.
   input wire logic [1:0] htrans, // Transfer type.
   input wire logic hwrite, // Write strobe.
   input wire logic [31:0] hrdata, // Read data.
   input wire logic hreadyout, // Ready.
   input wire logic hresp, // Response.
   input wire logic conv_busy, // Conversion running.
   input wire logic conv_press, // Pressure phase.
   input wire logic fifo_wr // FIFO strobe.
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic [9:0] boot_r; // Cycles since reset, saturating.
   // Counts the boot span so the quiet period can be checked.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) boot_r <= 10'h000;
      else if (boot_r != 10'h3ff) boot_r <= boot_r + 10'h001;
   end
   a_ready_high: assert property (hreadyout) else $error("ready low");
   a_resp_okay: assert property (!hresp) else $error("error response");
   a_boot_quiet: assert property (boot_r < 10'h316 |->
      !conv_busy && hrdata == 32'h0) else $error("active in boot");
   a_press_busy: assert property (conv_press |-> conv_busy)
      else $error("pressure outside busy");
   a_press_after: assert property ($rose(conv_press) |->
      $past(conv_busy)) else $error("pressure without temperature");
   a_busy_len: assert property ($rose(conv_busy) |->
      conv_busy[*8]) else $error("conversion too short");
   a_press_len: assert property ($rose(conv_press) |->
      conv_press[*8]) else $error("pressure too short");
   a_rdata_hold: assert property (!$past(hsel && htrans[1] && !hwrite)
      |-> $stable(hrdata)) else $error("read data moved");
   a_fifo_pulse: assert property (fifo_wr |->
      $past(conv_busy, 2) ##1 !fifo_wr) else $error("fifo strobe misplaced");
endmodule // pmc_chk

/* verification/pmc_sensor.sv */
// Sensor front end offering raw samples.
`timescale 1ns/1ps
module pmc_sensor (
   input wire logic hclk, // Clock.
   input wire logic conv_busy, // Samples hold while high.
   output logic [23:0] raw_temp, // Raw temperature.
   output logic [23:0] raw_press // Raw pressure.
);
   initial raw_temp = 24'h012345;
   initial raw_press = 24'h0abcde;
   // Samples step between conversions so each one sees a new value.
   always @(posedge hclk) begin
      if (!conv_busy) begin
         raw_temp <= raw_temp + 24'h000731;
         raw_press <= raw_press + 24'h000203;
      end
   end
endmodule // pmc_sensor

/* verification/tb_top.sv */
// Self-checking bench for the measurement control block.
`timescale 1ns/1ps
module tb_top;
   import pmc_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'b00;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
   logic hreadyout, hresp, conv_busy, conv_press;
   logic [23:0] raw_temp, raw_press, cap_t, prev_t, cap_p, ft, fp, fo;
   logic [31:0] lfsr = 32'hd286;
   int bad_count = 0, comparisons = 0, n, ot, op, pe, tc, pc;
   always #12.5 hclk = ~hclk;
   pmc_top #(.ODR_UNIT_CYC(40)) dut_u (.hclk(hclk), .hresetn(hresetn),
      .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .raw_temp(raw_temp), .raw_press(raw_press), .conv_busy(conv_busy),
      .conv_press(conv_press), .fifo_wr(), .fifo_t_data(ft),
      .fifo_p_data(fp), .oor_p_data(fo));
   pmc_sensor model_u (.hclk(hclk), .conv_busy(conv_busy),
      .raw_temp(raw_temp), .raw_press(raw_press));
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   task automatic ok(input logic c);
      comparisons++;
      if (c !== 1'b1) begin
         bad_count++;
         $display("unexpected at %0t: q=%h", $time, q);
      end
   endtask
   // One single AHB-Lite transfer; read data lands in q.
   task automatic bus(input logic w, input logic [5:0] a,
      input logic [31:0] d);
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {26'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      ok(q === e);
   endtask
   task automatic poll(input logic [5:0] a, input logic [31:0] m,
      input logic [31:0] v, input int lim);
      n = 0;
      do begin
         bus(1'b0, a, 32'h0);
         n++;
      end while ((q & m) !== v && n < lim);
      ok((q & m) === v);
   endtask
   // Forced measurement; counts cycles of each phase.
   task automatic meas();
      tc = 0;
      pc = 0;
      bus(1'b1, A_MODE, {30'h0, M_FORC});
      n = 0;
      while (conv_busy !== 1'b1 && n < 20) begin
         @(posedge hclk);
         n++;
      end
      ok(n < 6);
      while (conv_busy === 1'b1) begin
         @(posedge hclk);
         if (conv_press === 1'b1) pc++;
         else tc++;
      end
      cap_t = raw_temp;
      cap_p = raw_press;
      repeat (4) @(posedge hclk);
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #1000000;
      bad_count++;
      final_report();
   end
   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      hsel <= 1'b1;
      repeat (POWERUP_CYC) @(posedge hclk);
      poll(A_ID, 32'hff, {24'h0, ID_VALUE}, 4);
      rdc(A_MODE, {24'h0, 1'b0, ODR_DEEP_MIN, M_STBY});
      rdc(A_STAT, 32'h3);
      for (int i = 0; i < 4; i++) begin
         ot = (i == 0) ? 7 : int'(rnd() % 3);
         op = int'(rnd() % 3);
         pe = (i < 2) ? i : int'(rnd() & 1);
         bus(1'b1, A_OSR, 32'(pe << 6 | op << 3 | ot));
         meas();
         ok(tc >= (40 << ot) && tc <= (40 << ot) + 2);
         ok(pe ? pc >= (40 << op) && pc <= (40 << op) + 2 : pc == 0);
         rdc(A_MODE, 32'h0);
         rdc(A_TEMP, {8'h0, cap_t});
         ok(ft === cap_t);
         if (pe) ok(fp === cap_p && fo === cap_p);
         if (pe) rdc(A_PRESS, {8'h0, cap_p});
      end
      bus(1'b1, A_OSR, 32'h0);
      bus(1'b1, A_FSEL, 32'h1);
      bus(1'b1, A_IIR, 32'h1);
      bus(1'b1, A_DSP, 32'h3);
      meas();
      prev_t = cap_t;
      rdc(A_TEMP, {8'h0, cap_t});
      meas();
      rdc(A_TEMP, {8'h0, 24'(({1'b0, prev_t} + cap_t) >> 1)});
      bus(1'b1, A_MODE, {30'h0, M_NORM});
      bus(1'b1, A_IIR, 32'h2);
      rdc(A_IIR, 32'h1);
      bus(1'b1, A_MODE, {30'h0, M_CONT});
      rdc(A_MODE, {30'h0, M_NORM});
      bus(1'b1, A_MODE, 32'h0);
      rdc(A_MODE, {30'h0, M_NORM});
      poll(A_MODE, 32'h3, 32'h0, 50);
      rdc(6'h3c, 32'h0);
      bus(1'b1, A_CMD, {24'h0, CMD_SRST});
      poll(A_ID, 32'hff, 32'h0, 4);
      poll(A_ID, 32'hff, {24'h0, ID_VALUE}, 300);
      rdc(A_IIR, 32'h0);
      rdc(A_MODE, {24'h0, 1'b0, ODR_DEEP_MIN, M_STBY});
      rdc(A_STAT, 32'h3);
      final_report();
   end
endmodule // tb_top
bind pmc_top pmc_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .htrans(htrans), .hwrite(hwrite), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .conv_busy(conv_busy),
   .conv_press(conv_press), .fifo_wr(fifo_wr));
